// ---- shared/hcs_pkg.sv ----
// constants, error bit positions and mode codes for the hall commutation block
// assumes a 20 MHz system clock and 12-bit samples from an external converter
package hcs_pkg;
  localparam int CLK_HZ         = 20_000_000;
  localparam int CARRIER_HZ     = 20_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / CARRIER_HZ;
  localparam int PWM_CNT_W      = 10;
  localparam int MON_PERIOD_US  = 50;
  localparam int MON_PERIOD_CYC = MON_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int MON_CNT_W      = 10;
  localparam int HALL_TIMEOUT_MS  = 200;
  localparam int HALL_TIMEOUT_CYC = HALL_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SEC_PER_MIN    = 60;
  localparam int SPEED_NUM_BASE = SEC_PER_MIN * CLK_HZ;
  localparam int TIMER_W        = 32;
  localparam int HALL_EDGES_PER_REV = 6;

  localparam int ADC_W          = 12;
  localparam int ADC_MAX_CODE   = 4095;
  localparam logic [ADC_W-1:0] ADC_MID = 12'h800;
  localparam int I_SPAN_MA      = 25000;
  localparam int OC_LIMIT_MA    = 890;
  localparam int OC_LIMIT_CODE  = OC_LIMIT_MA * ADC_MAX_CODE / I_SPAN_MA;
  localparam int VDC_SPAN_V     = 111;
  localparam int OV_LIMIT_V     = 28;
  localparam int UV_LIMIT_V     = 14;
  localparam int OV_LIMIT_CODE  = OV_LIMIT_V * ADC_MAX_CODE / VDC_SPAN_V;
  localparam int UV_LIMIT_CODE  = UV_LIMIT_V * ADC_MAX_CODE / VDC_SPAN_V;

  localparam int MIN_SPEED_RPM  = 550;
  localparam int MAX_SPEED_RPM  = 2650;
  localparam int OVERSPEED_RPM  = 3000;
  localparam int KP_SHIFT       = 8;
  localparam int KI_SHIFT       = 12;

  localparam int ERR_HW_OC      = 0;
  localparam int ERR_SW_OC      = 1;
  localparam int ERR_OV         = 2;
  localparam int ERR_UV         = 3;
  localparam int ERR_SPEED      = 4;
  localparam int ERR_TIMEOUT    = 5;
  localparam int ERR_HALL       = 6;
  localparam int ERR_W          = 7;

  // {overcurrent_n, start_n, hall w, v, u}: both active-low pins idle high
  localparam logic [4:0] PIN_SYNC_RST = 5'h18;

  typedef enum logic [3:0] {
    MODE_STOP  = 4'h1,
    MODE_BOOT  = 4'h2,
    MODE_DRIVE = 4'h4,
    MODE_ERROR = 4'h8
  } hcs_mode_t;
endpackage

// ---- hdl/hcs_div.sv ----
// sequential restoring divider, one quotient bit per clock
// assumes start is ignored while busy; a zero divisor yields all ones
`timescale 1ns/1ps
`default_nettype none
module hcs_div #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // answer
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quot
);
  logic [W:0]         rem_reg;
  logic [W-1:0]       q_reg;
  logic [W-1:0]       d_reg;
  logic [7:0]         cnt_reg;
  logic [W:0]         shifted;
  logic [W:0]         trial;

  assign shifted = {rem_reg[W-1:0], q_reg[W-1]};
  assign trial   = shifted - {1'b0, d_reg};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rem_reg <= '0;
      q_reg   <= '0;
      d_reg   <= '0;
      cnt_reg <= 8'h00;
      busy    <= 1'b0;
      done    <= 1'b0;
      quot    <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_reg <= '0;
        q_reg   <= num;
        d_reg   <= den;
        cnt_reg <= 8'(W);
        busy    <= 1'b1;
      end else if (busy) begin
        if (trial[W]) begin
          rem_reg <= shifted;
          q_reg   <= {q_reg[W-2:0], 1'b0};
        end else begin
          rem_reg <= trial;
          q_reg   <= {q_reg[W-2:0], 1'b1};
        end
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= {q_reg[W-2:0], ~trial[W]};
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // one cycle to load, then W shift cycles; done is seen one edge after the last
  a_div_latency: assert property ((start && !busy) |-> ##33 done)
    else $error("divider did not finish in W plus one cycles");
endmodule
`default_nettype wire

// ---- hdl/hcs_chop.sv ----
// carrier counter and first-60-degree chopper for the six gate signals
// assumes hi_sel/lo_sel are one-hot per sector; no dead time is inserted
`timescale 1ns/1ps
`default_nettype none
module hcs_chop (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // conduction control
  input  wire logic                          enable,
  input  wire logic                          compl_mode,
  input  wire logic                          chop_hi,
  input  wire logic [2:0]                    hi_sel,
  input  wire logic [2:0]                    lo_sel,
  input  wire logic [hcs_pkg::PWM_CNT_W-1:0] duty,
  // gates
  output logic [2:0]                         gate_hi,
  output logic [2:0]                         gate_lo
);
  import hcs_pkg::*;

  logic [PWM_CNT_W-1:0] carrier_reg;
  logic                 pwm_on;
  logic [2:0]           hi_next;
  logic [2:0]           lo_next;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carrier_reg <= '0;
    end else if (carrier_reg == PWM_CNT_W'(PWM_PERIOD_CYC - 1)) begin
      carrier_reg <= '0;
    end else begin
      carrier_reg <= carrier_reg + PWM_CNT_W'(1);
    end
  end

  assign pwm_on = carrier_reg < duty;

  // only the switch in its first 60 degrees chops; the partner of that leg
  // takes the inverse pulse in complementary mode
  for (genvar k = 0; k < 3; k++) begin : g_leg
    assign hi_next[k] = (hi_sel[k] & (chop_hi ? pwm_on : 1'b1))
                      | (compl_mode & ~chop_hi & lo_sel[k] & ~pwm_on);
    assign lo_next[k] = (lo_sel[k] & (chop_hi ? 1'b1 : pwm_on))
                      | (compl_mode & chop_hi & hi_sel[k] & ~pwm_on);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gate_hi <= 3'h0;
      gate_lo <= 3'h0;
    end else if (!enable) begin
      gate_hi <= 3'h0;
      gate_lo <= 3'h0;
    end else begin
      gate_hi <= hi_next;
      gate_lo <= lo_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_no_shoot_through: assert property ((gate_hi & gate_lo) == 3'h0)
    else $error("both switches of a leg are on");
  a_disable_clears: assert property (!enable |=> (gate_hi == 3'h0 && gate_lo == 3'h0))
    else $error("gates active while disabled");
  c_compl_chop: cover property (enable && compl_mode && chop_hi && !pwm_on);
endmodule
`default_nettype wire

// ---- hdl/hcs_top.sv ----
// hall-sensor 120-degree drive: speed capture, pi loop, duty, modes, protection
// assumes analog samples and commands come from logic on clk; pins are async
`timescale 1ns/1ps
`default_nettype none
module hcs_top #(
  parameter int HALL_TIMEOUT_CYC = hcs_pkg::HALL_TIMEOUT_CYC,
  parameter int POLE_PAIRS       = 2
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // pins, asynchronous
  input  wire logic                      hall_u,
  input  wire logic                      hall_v,
  input  wire logic                      hall_w,
  input  wire logic                      hw_overcurrent_stop_n,
  input  wire logic                      start_switch_n,
  // converter samples
  input  wire logic [hcs_pkg::ADC_W-1:0] phase_i_u,
  input  wire logic [hcs_pkg::ADC_W-1:0] phase_i_v,
  input  wire logic [hcs_pkg::ADC_W-1:0] phase_i_w,
  input  wire logic [hcs_pkg::ADC_W-1:0] bus_voltage,
  // commands and settings
  input  wire logic [11:0]               speed_knob_rpm,
  input  wire logic                      dir_ccw,
  input  wire logic [hcs_pkg::ADC_W-1:0] startup_voltage_setting,
  input  wire logic [15:0]               speed_kp,
  input  wire logic [15:0]               speed_ki,
  input  wire logic                      compl_chop,
  input  wire logic                      err_clear,
  // gate outputs
  output logic [2:0]                     gate_hi,
  output logic [2:0]                     gate_lo,
  output logic                           gate_oe,
  // status
  output hcs_pkg::hcs_mode_t             mode,
  output logic [hcs_pkg::ERR_W-1:0]      err_flags,
  output logic [15:0]                    speed_rpm
);
  import hcs_pkg::*;

  logic [4:0]           pin_meta_reg;
  logic [4:0]           pin_sync_reg;
  logic [2:0]           hall_prev_reg;
  logic [2:0]           hall_s;
  logic                 hall_edge;
  logic                 hall_bad;
  logic                 oc_stop;
  hcs_mode_t            mode_reg;
  hcs_mode_t            mode_next;
  logic                 running;
  logic                 run_req;
  logic [11:0]          ref_rpm;
  logic [MON_CNT_W-1:0] mon_cnt_reg;
  logic                 tick;
  logic                 duty_go_reg;
  logic [TIMER_W-1:0]   timer_reg;
  logic [TIMER_W-1:0]   cap_mem [HALL_EDGES_PER_REV];
  logic [2:0]           ptr_reg;
  logic [2:0]           ncap_reg;
  logic                 rev_ready;
  logic [TIMER_W-1:0]   rev_delta;
  logic                 sdiv_done;
  logic [TIMER_W-1:0]   sdiv_quot;
  logic                 ddiv_done;
  logic [TIMER_W-1:0]   ddiv_quot;
  logic [TIMER_W-1:0]   idle_cnt_reg;
  logic [ADC_W-1:0]     phase_i [3];
  logic [2:0]           oc_ph;
  logic [ERR_W-1:0]     fault_now;
  logic                 err_any;
  logic                 dir_reg;
  logic [5:0]           comm;
  logic                 chop_hi;
  logic signed [17:0]   speed_err;
  logic signed [35:0]   p_term;
  logic signed [35:0]   integ_reg;
  logic signed [35:0]   integ_next;
  logic [ADC_W-1:0]     v_cmd_reg;
  logic [PWM_CNT_W-1:0] duty_reg;

  function automatic logic signed [35:0] clamp_v(input logic signed [35:0] x);
    if (x < 0) begin
      return 36'sh0;
    end else if (x > 36'(ADC_MAX_CODE)) begin
      return 36'(ADC_MAX_CODE);
    end
    return x;
  endfunction

  // pins: two flops before anything looks at them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg  <= PIN_SYNC_RST;
      pin_sync_reg  <= PIN_SYNC_RST;
      hall_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg  <= {hw_overcurrent_stop_n, start_switch_n, hall_w, hall_v, hall_u};
      pin_sync_reg  <= pin_meta_reg;
      hall_prev_reg <= pin_sync_reg[2:0];
    end
  end

  assign hall_s    = pin_sync_reg[2:0];
  assign oc_stop   = !pin_sync_reg[4];
  assign hall_edge = hall_s != hall_prev_reg;
  assign hall_bad  = (hall_s == 3'h0) || (hall_s == 3'h7);
  assign running   = (mode_reg == MODE_BOOT) || (mode_reg == MODE_DRIVE);
  assign ref_rpm   = (speed_knob_rpm > 12'(MAX_SPEED_RPM)) ? 12'(MAX_SPEED_RPM)
                                                           : speed_knob_rpm;
  assign run_req   = !pin_sync_reg[3] && (ref_rpm >= 12'(MIN_SPEED_RPM));

  // monitoring tick; the duty division starts one cycle later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mon_cnt_reg <= '0;
      duty_go_reg <= 1'b0;
    end else begin
      mon_cnt_reg <= tick ? '0 : mon_cnt_reg + MON_CNT_W'(1);
      duty_go_reg <= tick;
    end
  end
  assign tick = mon_cnt_reg == MON_CNT_W'(MON_PERIOD_CYC - 1);

  // timer capture ring: the slot about to be overwritten is six edges old
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_reg <= '0;
      ptr_reg   <= 3'h0;
      ncap_reg  <= 3'h0;
    end else begin
      timer_reg <= timer_reg + TIMER_W'(1);
      if (!running) begin
        ptr_reg  <= 3'h0;
        ncap_reg <= 3'h0;
      end else if (hall_edge) begin
        ptr_reg  <= (ptr_reg == 3'(HALL_EDGES_PER_REV - 1)) ? 3'h0 : ptr_reg + 3'h1;
        ncap_reg <= rev_ready ? ncap_reg : ncap_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (running && hall_edge) begin
      cap_mem[ptr_reg] <= timer_reg;
    end
  end

  assign rev_ready = ncap_reg == 3'(HALL_EDGES_PER_REV);
  assign rev_delta = timer_reg - cap_mem[ptr_reg];

  // rpm = 60 * f_clk / (cycles per electrical turn * pole pairs)
  hcs_div #(.W(TIMER_W)) u_speed_div (
    .clk   (clk),
    .nrst  (nrst),
    .start (running && hall_edge && rev_ready),
    .num   (TIMER_W'(SPEED_NUM_BASE / POLE_PAIRS)),
    .den   (rev_delta),
    .busy  (),
    .done  (sdiv_done),
    .quot  (sdiv_quot)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_rpm <= 16'h0000;
    end else if (!running) begin
      speed_rpm <= 16'h0000;
    end else if (sdiv_done) begin
      speed_rpm <= (sdiv_quot > 32'h0000FFFF) ? 16'hFFFF : sdiv_quot[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_reg <= '0;
    end else if (!running || hall_edge) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != '1) begin
      idle_cnt_reg <= idle_cnt_reg + TIMER_W'(1);
    end
  end

  assign phase_i[0] = phase_i_u;
  assign phase_i[1] = phase_i_v;
  assign phase_i[2] = phase_i_w;
  for (genvar g = 0; g < 3; g++) begin : g_oc
    logic [ADC_W:0] mag;
    assign mag = (phase_i[g] >= ADC_MID) ? {1'b0, phase_i[g]} - {1'b0, ADC_MID}
                                         : {1'b0, ADC_MID} - {1'b0, phase_i[g]};
    assign oc_ph[g] = mag > (ADC_W + 1)'(OC_LIMIT_CODE);
  end

  // software checks only while the motor is driven, the hall check also on a start request in stop; the pin always counts
  always_comb begin
    fault_now              = '0;
    fault_now[ERR_HW_OC]   = oc_stop;
    fault_now[ERR_SW_OC]   = running && tick && (|oc_ph);
    fault_now[ERR_OV]      = running && tick && (bus_voltage > 12'(OV_LIMIT_CODE));
    fault_now[ERR_UV]      = running && tick && (bus_voltage < 12'(UV_LIMIT_CODE));
    fault_now[ERR_SPEED]   = running && tick && (speed_rpm > 16'(OVERSPEED_RPM));
    fault_now[ERR_TIMEOUT] = running && (idle_cnt_reg >= TIMER_W'(HALL_TIMEOUT_CYC));
    fault_now[ERR_HALL]    = hall_bad && ((running && hall_edge)
                           || (mode_reg == MODE_STOP && run_req));
  end
  assign err_any = |fault_now;

  // a fault in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_flags <= '0;
    end else if (mode_reg == MODE_ERROR && err_clear) begin
      err_flags <= fault_now;
    end else begin
      err_flags <= err_flags | fault_now;
    end
  end

  always_comb begin
    mode_next = mode_reg;
    if (err_any) begin
      mode_next = MODE_ERROR;
    end else begin
      unique case (mode_reg)
        MODE_STOP: begin
          if (run_req) mode_next = MODE_BOOT;
        end
        MODE_BOOT: begin
          if (!run_req) begin
            mode_next = MODE_STOP;
          end else if (rev_ready && speed_rpm >= 16'(MIN_SPEED_RPM)) begin
            mode_next = MODE_DRIVE;
          end
        end
        MODE_DRIVE: begin
          if (!run_req) mode_next = MODE_STOP;
        end
        MODE_ERROR: begin
          if (err_clear) mode_next = MODE_STOP;
        end
        default: mode_next = MODE_ERROR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_STOP;
      dir_reg  <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (mode_reg == MODE_STOP) dir_reg <= dir_ccw;
    end
  end
  assign mode = mode_reg;

  assign speed_err  = $signed({6'h00, ref_rpm}) - $signed({2'b00, speed_rpm});
  assign p_term     = 36'($signed({1'b0, speed_kp}) * speed_err) >>> KP_SHIFT;
  assign integ_next = clamp_v(integ_reg
                    + (36'($signed({1'b0, speed_ki}) * speed_err) >>> KI_SHIFT));

  // integrator preloaded with the boot voltage for a smooth hand-over
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      integ_reg <= 36'sh0;
      v_cmd_reg <= '0;
    end else if (mode_reg == MODE_BOOT) begin
      integ_reg <= 36'($signed({1'b0, startup_voltage_setting}));
      v_cmd_reg <= startup_voltage_setting;
    end else if (mode_reg == MODE_DRIVE) begin
      if (tick) begin
        integ_reg <= integ_next;
        v_cmd_reg <= ADC_W'(clamp_v(p_term + integ_next));
      end
    end else begin
      integ_reg <= 36'sh0;
      v_cmd_reg <= '0;
    end
  end

  hcs_div #(.W(TIMER_W)) u_duty_div (
    .clk   (clk),
    .nrst  (nrst),
    .start (duty_go_reg),
    .num   (TIMER_W'(v_cmd_reg) * TIMER_W'(PWM_PERIOD_CYC)),
    .den   (TIMER_W'(bus_voltage)),
    .busy  (),
    .done  (ddiv_done),
    .quot  (ddiv_quot)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      duty_reg <= '0;
    end else if (ddiv_done) begin
      duty_reg <= (ddiv_quot > TIMER_W'(PWM_PERIOD_CYC)) ? PWM_CNT_W'(PWM_PERIOD_CYC)
                                                         : ddiv_quot[PWM_CNT_W-1:0];
    end
  end

  // sector table for one direction; the other direction swaps the switches
  always_comb begin
    unique case (hall_s)
      3'h1: comm = 6'b001_010;
      3'h3: comm = 6'b001_100;
      3'h2: comm = 6'b010_100;
      3'h6: comm = 6'b010_001;
      3'h4: comm = 6'b100_001;
      3'h5: comm = 6'b100_010;
      default: comm = 6'b000_000;
    endcase
  end
  assign chop_hi = (hall_s == 3'h1) || (hall_s == 3'h2) || (hall_s == 3'h4);

  hcs_chop u_chop (
    .clk        (clk),
    .nrst       (nrst),
    .enable     (running && !err_any),
    .compl_mode (compl_chop),
    .chop_hi    (chop_hi ^ dir_reg),
    .hi_sel     (dir_reg ? comm[2:0] : comm[5:3]),
    .lo_sel     (dir_reg ? comm[5:3] : comm[2:0]),
    .duty       (duty_reg),
    .gate_hi    (gate_hi),
    .gate_lo    (gate_lo)
  );

  assign gate_oe = running && !oc_stop;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_hw_stop_float: assert property ($fell(hw_overcurrent_stop_n) |-> ##[1:3] !gate_oe)
    else $error("gates still driven after overcurrent pin");
  a_err_gates_off: assert property ((mode_reg == MODE_ERROR) |=> (gate_hi | gate_lo) == 3'h0)
    else $error("gate active in error mode");
  a_overvolt_trip: assert property ((running && tick && bus_voltage > 12'(OV_LIMIT_CODE))
    |=> err_flags[ERR_OV] && mode_reg == MODE_ERROR)
    else $error("overvoltage missed");
  a_undervolt_trip: assert property ((running && tick && bus_voltage < 12'(UV_LIMIT_CODE))
    |=> err_flags[ERR_UV])
    else $error("undervoltage missed");
  a_overcur_trip: assert property ((running && tick && |oc_ph) |=> err_flags[ERR_SW_OC])
    else $error("phase overcurrent missed");
  a_overspeed_trip: assert property ((running && tick && speed_rpm > 16'(OVERSPEED_RPM))
    |=> mode_reg == MODE_ERROR)
    else $error("overspeed missed");
  a_hall_timeout: assert property ((running && idle_cnt_reg >= TIMER_W'(HALL_TIMEOUT_CYC))
    |=> err_flags[ERR_TIMEOUT])
    else $error("hall timeout missed");
  a_bad_pattern: assert property ((running && hall_edge && hall_bad) |=> err_flags[ERR_HALL])
    else $error("invalid hall pattern missed");
  a_capture_slot: assert property ((running && hall_edge)
    |=> cap_mem[$past(ptr_reg)] == $past(timer_reg))
    else $error("timer not captured on hall edge");
  a_boot_handover: assert property ((mode_reg == MODE_BOOT && !err_any && run_req && rev_ready
    && speed_rpm >= 16'(MIN_SPEED_RPM)) |=> mode_reg == MODE_DRIVE)
    else $error("boot did not hand over to drive");
  a_low_ref_stops: assert property ((running && !err_any && ref_rpm < 12'(MIN_SPEED_RPM))
    |=> mode_reg == MODE_STOP)
    else $error("low speed command did not stop");
  a_error_sticks: assert property ((mode_reg == MODE_ERROR && !err_clear)
    |=> mode_reg == MODE_ERROR)
    else $error("left error mode without clear");

  c_boot_to_drive: cover property (mode_reg == MODE_BOOT ##1 mode_reg == MODE_DRIVE);
  c_error_entry: cover property (running ##1 mode_reg == MODE_ERROR);
  c_drive_edge: cover property (mode_reg == MODE_DRIVE && hall_edge && sdiv_done == 1'b0);
  c_clear_restart: cover property (mode_reg == MODE_ERROR ##1 mode_reg == MODE_STOP);
endmodule
`default_nettype wire

// ---- verification/hcs_motor_model.sv ----
// motor with hall sensors: steps one sector every STEP clocks while spinning
// assumes the block's clock; fault models a broken sensor harness
`timescale 1ns/1ps
`default_nettype none
module hcs_motor_model #(
  parameter int STEP = 2000
) (
  // bench control
  input  wire logic clk,
  input  wire logic spin,
  input  wire logic fault,
  // sensor pins
  output logic      hall_u,
  output logic      hall_v,
  output logic      hall_w
);
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int         idx = 0;
  int         cnt = 0;
  // push-pull sensors, so the pins are never released
  assign {hall_w, hall_v, hall_u} = fault ? 3'h0 : seq[idx];
  always @(posedge clk) begin
    if (spin && cnt == STEP - 1) begin
      cnt <= 0;
      idx <= (idx + 1) % 6;
    end else begin
      cnt <= spin ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the hall commutation block
// assumes a 20 MHz clock; hall timeout shortened to 20000 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hcs_pkg::*;
  logic clk = 0, nrst = 0, oc_n = 1, start_n = 1, spin = 0, hfault = 0, clr = 0;
  logic cmpl = 0, ccw = 0;
  logic hu, hv, hw;
  logic [11:0] cur = 12'h800, bus = 12'h375, knob = 12'h3E8;
  logic [2:0]  g_hi, g_lo;
  logic        g_oe;
  hcs_mode_t   mode;
  logic [6:0]  flags;
  logic [15:0] spd;
  int          error_cnt = 0, samples_checked = 0;
  always #25 clk = ~clk;
  hcs_motor_model hcs_motor_model_inst (.clk(clk), .spin(spin), .fault(hfault),
    .hall_u(hu), .hall_v(hv), .hall_w(hw));
  hcs_top #(.HALL_TIMEOUT_CYC(20000)) hcs_top_inst (.clk(clk), .nrst(nrst), .hall_u(hu),
    .hall_v(hv), .hall_w(hw), .hw_overcurrent_stop_n(oc_n), .start_switch_n(start_n),
    .phase_i_u(cur), .phase_i_v(cur), .phase_i_w(cur), .bus_voltage(bus),
    .speed_knob_rpm(knob), .dir_ccw(ccw), .startup_voltage_setting(12'h1BB),
    .speed_kp(16'h0100), .speed_ki(16'h0010), .compl_chop(cmpl), .err_clear(clr),
    .gate_hi(g_hi), .gate_lo(g_lo), .gate_oe(g_oe), .mode(mode), .err_flags(flags),
    .speed_rpm(spd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_mode(input hcs_mode_t m, input int n);
    for (int i = 0; i < n && mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk(mode, m);
  endtask
  task automatic go;
    @(posedge clk) start_n <= 1'h0;
    wait_mode(MODE_BOOT, 6);
  endtask
  task automatic recover;
    @(posedge clk) start_n <= 1'h1;
    // let the released start pin through the synchroniser before clearing
    repeat (3) @(posedge clk);
    clr <= 1'h1;
    wait_mode(MODE_STOP, 4);
    chk(flags, 16'h0000);
    @(posedge clk) clr <= 1'h0;
  endtask
  task automatic t_start(input logic d);
    int n;
    int m;
    n = 0;
    m = 0;
    @(posedge clk) ccw <= d;
    go();
    repeat (3) @(posedge clk);
    #1 chk(g_oe, 16'h0001);
    chk(d ? g_hi : g_lo, 16'h0002);
    @(posedge clk) cmpl <= 1'h1;
    repeat (1100) @(posedge clk);
    // chopped switch of leg u and its complementary partner
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      #1 n += ((d ? g_lo[0] : g_hi[0]) === 1'h1);
      m += ((d ? g_hi[0] : g_lo[0]) === 1'h1);
    end
    chk(n[15:0], 16'h01F4);
    chk(m[15:0], 16'h01F4);
    @(posedge clk) knob <= 12'h200;
    wait_mode(MODE_STOP, 6);
    @(posedge clk) start_n <= 1'h1;
    cmpl <= 1'h0;
    ccw <= 1'h0;
    repeat (3) @(posedge clk);
    knob <= 12'h3E8;
    $display("start test done");
  endtask
  task automatic t_overspeed;
    @(posedge clk) spin <= 1'h1;
    go();
    wait_mode(MODE_DRIVE, 14100);
    chk(spd, 16'hC350);
    wait_mode(MODE_ERROR, 2000);
    chk(flags, 16'h0010);
    chk({g_hi, g_lo}, 16'h0000);
    @(posedge clk) spin <= 1'h0;
    recover();
    $display("overspeed test done");
  endtask
  task automatic t_timeout;
    go();
    wait_mode(MODE_ERROR, 21000);
    chk(flags, 16'h0020);
    recover();
    $display("timeout test done");
  endtask
  task automatic t_sense(input logic [11:0] b, input logic [11:0] c, input logic [6:0] f);
    go();
    @(posedge clk) bus <= b;
    cur <= c;
    wait_mode(MODE_ERROR, 1010);
    chk(flags, f);
    chk(g_oe, 16'h0000);
    @(posedge clk) bus <= 12'h375;
    cur <= 12'h800;
    recover();
    $display("sense test done");
  endtask
  task automatic t_faults;
    @(posedge clk) hfault <= 1'h1;
    start_n <= 1'h0;
    wait_mode(MODE_ERROR, 6);
    chk(flags, 16'h0040);
    @(posedge clk) hfault <= 1'h0;
    recover();
    go();
    @(posedge clk) oc_n <= 1'h0;
    repeat (4) @(posedge clk);
    #1 chk(g_oe, 16'h0000);
    chk(flags, 16'h0001);
    @(posedge clk) oc_n <= 1'h1;
    recover();
    $display("fault test done");
  endtask
  task automatic print_verdict;
    $display("%0d compares, %0d mismatches", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #4_000_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    #1 chk(mode, MODE_STOP);
    t_start(1'h0);
    t_start(1'h1);
    t_overspeed();
    t_timeout();
    t_sense(12'h44C, 12'h800, 7'h04);
    t_sense(12'h1F4, 12'h800, 7'h08);
    t_sense(12'h375, 12'h8A0, 7'h02);
    t_faults();
    print_verdict();
  end
endmodule
`default_nettype wire
